/* File: hdl/sbc_regs.sv */
// Configuration and status bits of the cable PHY with APB access
//
// Behaviour
// - The speed capability field is read-only and always reads 010b.
// - The four-bit repeater delay code (144 ns plus 20 ns per step) is read-only and reads zero.
// - Self-ID bit 9 carries link_active_control ANDed with an active link power status input.
// - link_active_control is one after hardware reset and keeps its value through bus resets.
// - While link power status is active the link interface stays enabled whatever link_active_control holds.
// - The contender bit feeds self-ID bit 20, loads the contender pin at hardware reset, survives bus reset.
// - The three-bit repeater jitter code ((code+1) times 20 ns) is read-only and reads zero.
// - Power class feeds self-ID bits 21 to 23, loads the power class pins at reset, survives bus reset.
// - With resume_event_enable set, resume start on any port sets the port event flag; enable clears on reset only.
// - Writing one to short_reset_request starts a 1.30 us arbitrated short bus reset at the next chance; bus reset clears it.
// - When some node cannot do short resets, a requested short reset becomes a long one.
// - config_timeout_flag sets on arbitration timeout at tree-ID start and clears on reset or write of one.
// - Config timeout or cable power drop with resume enable while the link is inactive drives the link-on output.
// - cable_power_drop_flag sets on each falling edge of cable power sense, is one after reset, clears on write of one.
// - state_timeout_flag sets on a state timeout, which also starts a bus reset; clears on reset or write of one.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "sbc_cfg.svh"

module sbc_regs #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 16,
    parameter int SHORT_RST_CYCLES = `SBC_SHORT_RST_CYCLES,
    parameter int LONG_RST_CYCLES = `SBC_LONG_RST_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic LINK_POWER_STATUS_INPUT,
    input wire logic CABLE_POWER_SENSE,
    input wire logic CONTENDER_LINKON_PIN,
    input wire logic [2:0] POWER_CLASS_PINS,
    input wire sbc_pkg::sbc_arb_evt_t ARB_EVT,
    input wire logic ARB_IDLE,
    input wire logic SHORT_RESET_OK,
    output logic CONTENDER_LINKON_OUT,
    output logic LINK_IF_ENABLE,
    output sbc_pkg::sbc_selfid_t SELF_ID,
    output logic BUS_RESET_ACTIVE,
    output logic BUS_RESET_SHORT,
    output logic PORT_EVENT_FLAG,
    output logic IRQ
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [3:0] idx);
        reg_addr = ADDR_W'({idx, 2'h0});
    endfunction : reg_addr

    // True when the bus address selects the given register index
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [3:0] idx);
        addr_hit = (addr == reg_addr(idx));
    endfunction : addr_hit

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic lps_meta;
    logic lps_sync;
    logic cps_meta;
    logic cps_sync;
    logic cps_prev;
    logic cont_meta;
    logic cont_sync;
    logic [2:0] pc_meta;
    logic [2:0] pc_sync;

    // Two flops on every pin coming from outside the clock domain
    always_ff @(posedge SYS_CLK)
    begin
        lps_meta <= LINK_POWER_STATUS_INPUT;
        lps_sync <= lps_meta;
        cps_meta <= CABLE_POWER_SENSE;
        cps_sync <= cps_meta;
        cont_meta <= CONTENDER_LINKON_PIN;
        cont_sync <= cont_meta;
        pc_meta <= POWER_CLASS_PINS;
        pc_sync <= pc_meta;
    end

    // Previous cable power level for edge detection
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            cps_prev <= 1'h0;
        end
        else
        begin
            cps_prev <= cps_sync;
        end
    end

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    logic access;
    logic wr_stb;
    logic [7:0] wd;
    logic mapped;
    logic writable;

    assign access = PSEL & PENABLE & ~PREADY;
    assign wd = PWDATA[7:0];
    assign mapped = addr_hit(PADDR, `SBC_IDX_CAPS) | addr_hit(PADDR, `SBC_IDX_SELFID) |
                    addr_hit(PADDR, `SBC_IDX_EVENTS) | addr_hit(PADDR, `SBC_IDX_IRQ_STATUS) |
                    addr_hit(PADDR, `SBC_IDX_IRQ_CLEAR) | addr_hit(PADDR, `SBC_IDX_IRQ_ENABLE);
    // Read-only registers ignore writes without an error
    assign writable = mapped;
    // Write takes effect at the edge where PREADY is sampled high
    assign wr_stb = PSEL & PENABLE & PREADY & PWRITE & writable;

    // ------------------------------------------------------------------------
    // Self-ID source registers
    // ------------------------------------------------------------------------
    logic link_active_control;
    logic contender;
    logic [2:0] power_class;
    logic link_active;

    // Link control: set by hardware reset only, bus reset has no effect
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            link_active_control <= `SBC_RST_LINK_CTRL;
        end
        else if (wr_stb && addr_hit(PADDR, `SBC_IDX_SELFID))
        begin
            link_active_control <= wd[`SBC_BIT_LINK_CTRL];
        end
    end

    // Contender and power class load the pins at hardware reset
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            contender <= cont_sync;
            power_class <= pc_sync;
        end
        else if (wr_stb && addr_hit(PADDR, `SBC_IDX_SELFID))
        begin
            contender <= wd[`SBC_BIT_CONTENDER];
            power_class <= wd[2:0];
        end
    end

    assign link_active = link_active_control & lps_sync;

    // Self-ID copies and link interface enable
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            SELF_ID <= '0;
            LINK_IF_ENABLE <= 1'h0;
        end
        else
        begin
            SELF_ID.link_active <= link_active;
            SELF_ID.contender <= contender;
            SELF_ID.power_class <= power_class;
            LINK_IF_ENABLE <= lps_sync;
        end
    end

    // ------------------------------------------------------------------------
    // Event register
    // ------------------------------------------------------------------------
    logic resume_event_enable;
    logic short_reset_request;
    logic config_timeout_flag;
    logic cable_power_drop_flag;
    logic state_timeout_flag;
    logic accel_arb;
    logic multi_speed;
    logic ev_wr;
    logic cps_fall;
    logic rst_begin;

    assign ev_wr = wr_stb & addr_hit(PADDR, `SBC_IDX_EVENTS);
    assign cps_fall = cps_prev & ~cps_sync;

    // Plain enables, cleared by hardware reset only
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            resume_event_enable <= 1'h0;
            accel_arb <= 1'h0;
            multi_speed <= 1'h0;
        end
        else if (ev_wr)
        begin
            resume_event_enable <= wd[`SBC_BIT_RESUME_EN];
            accel_arb <= wd[`SBC_BIT_ACCEL_ARB];
            multi_speed <= wd[`SBC_BIT_MULTI_SPEED];
        end
    end

    // Short reset request: a write of one wins over a clearing bus reset
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            short_reset_request <= 1'h0;
        end
        else if (ev_wr && wd[`SBC_BIT_SHORT_RST])
        begin
            short_reset_request <= 1'h1;
        end
        else if (ev_wr || rst_begin || ARB_EVT.bus_reset_seen)
        begin
            short_reset_request <= 1'h0;
        end
    end

    // Configuration timeout flag
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            config_timeout_flag <= 1'h0;
        end
        else if (ARB_EVT.cfg_timeout)
        begin
            config_timeout_flag <= 1'h1;
        end
        else if (ev_wr && wd[`SBC_BIT_CFG_TO])
        begin
            config_timeout_flag <= 1'h0;
        end
    end

    // Cable power drop flag, set at reset
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            cable_power_drop_flag <= `SBC_RST_CPWR_DROP;
        end
        else if (cps_fall)
        begin
            cable_power_drop_flag <= 1'h1;
        end
        else if (ev_wr && wd[`SBC_BIT_CPWR_DROP])
        begin
            cable_power_drop_flag <= 1'h0;
        end
    end

    // State timeout flag
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            state_timeout_flag <= 1'h0;
        end
        else if (ARB_EVT.state_timeout)
        begin
            state_timeout_flag <= 1'h1;
        end
        else if (ev_wr && wd[`SBC_BIT_STATE_TO])
        begin
            state_timeout_flag <= 1'h0;
        end
    end

    // Port event flag, set by resume start when enabled
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            PORT_EVENT_FLAG <= 1'h0;
        end
        else if (ARB_EVT.resume_start && resume_event_enable)
        begin
            PORT_EVENT_FLAG <= 1'h1;
        end
        else if (ev_wr && wd[`SBC_BIT_PORT_EVT])
        begin
            PORT_EVENT_FLAG <= 1'h0;
        end
    end

    // Wake the link while a flag is pending, resume_event_enable is set and the link is inactive
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            CONTENDER_LINKON_OUT <= 1'h0;
        end
        else
        begin
            CONTENDER_LINKON_OUT <= resume_event_enable & ~link_active &
                (config_timeout_flag | cable_power_drop_flag | state_timeout_flag);
        end
    end

    // ------------------------------------------------------------------------
    // Bus reset sequencer
    // ------------------------------------------------------------------------
    sbc_pkg::sbc_rst_state_t rst_state;
    logic [CNT_W-1:0] rst_cnt;
    logic long_pending;

    // A state timeout forces a long reset, waiting for the bus to go idle
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            long_pending <= 1'h0;
        end
        else if (ARB_EVT.state_timeout)
        begin
            long_pending <= 1'h1;
        end
        else if (rst_begin)
        begin
            long_pending <= 1'h0;
        end
    end

    assign rst_begin = (rst_state == sbc_pkg::SBC_RST_WAIT) && ARB_IDLE;

    // Waits for an idle bus, then holds the reset for its duration
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            rst_state <= sbc_pkg::SBC_RST_IDLE;
            rst_cnt <= '0;
            BUS_RESET_ACTIVE <= 1'h0;
            BUS_RESET_SHORT <= 1'h0;
        end
        else
        begin
            unique case (rst_state)
                sbc_pkg::SBC_RST_IDLE:
                begin
                    if (short_reset_request || long_pending)
                    begin
                        rst_state <= sbc_pkg::SBC_RST_WAIT;
                    end
                end
                sbc_pkg::SBC_RST_WAIT:
                begin
                    if (ARB_IDLE)
                    begin
                        rst_state <= sbc_pkg::SBC_RST_RUN;
                        BUS_RESET_ACTIVE <= 1'h1;
                        if (long_pending || !SHORT_RESET_OK)
                        begin
                            BUS_RESET_SHORT <= 1'h0;
                            rst_cnt <= CNT_W'(LONG_RST_CYCLES - 1);
                        end
                        else
                        begin
                            BUS_RESET_SHORT <= 1'h1;
                            rst_cnt <= CNT_W'(SHORT_RST_CYCLES - 1);
                        end
                    end
                end
                sbc_pkg::SBC_RST_RUN:
                begin
                    if (rst_cnt == '0)
                    begin
                        rst_state <= sbc_pkg::SBC_RST_IDLE;
                        BUS_RESET_ACTIVE <= 1'h0;
                        BUS_RESET_SHORT <= 1'h0;
                    end
                    else
                    begin
                        rst_cnt <= rst_cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------------------
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;

    assign irq_set = {PORT_EVENT_FLAG == 1'h0 && ARB_EVT.resume_start && resume_event_enable,
                      ARB_EVT.state_timeout, cps_fall, ARB_EVT.cfg_timeout};
    assign irq_clr = (wr_stb && addr_hit(PADDR, `SBC_IDX_IRQ_CLEAR)) ? PWDATA[3:0] : 4'h0;

    // Sticky bits; a new event wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            irq_status <= 4'h0;
        end
        else
        begin
            irq_status <= irq_set | (irq_status & ~irq_clr);
        end
    end

    // Enable mask
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            irq_enable <= 4'h0;
        end
        else if (wr_stb && addr_hit(PADDR, `SBC_IDX_IRQ_ENABLE))
        begin
            irq_enable <= PWDATA[3:0];
        end
    end

    // Level interrupt output
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            IRQ <= 1'h0;
        end
        else
        begin
            IRQ <= |(irq_status & irq_enable);
        end
    end

    // ------------------------------------------------------------------------
    // APB read data and answer
    // ------------------------------------------------------------------------
    logic [31:0] next_prdata;

    // Read multiplexer, reserved bits and unmapped words read zero
    always_comb
    begin
        next_prdata = 32'h0;
        if (addr_hit(PADDR, `SBC_IDX_CAPS))
        begin
            next_prdata[7:0] = {`SBC_SPEED_CAP, 1'h0, `SBC_REPEATER_DELAY};
        end
        else if (addr_hit(PADDR, `SBC_IDX_SELFID))
        begin
            next_prdata[7:0] = {link_active_control, contender, `SBC_REPEATER_JITTER, power_class};
        end
        else if (addr_hit(PADDR, `SBC_IDX_EVENTS))
        begin
            next_prdata[7:0] = {resume_event_enable, short_reset_request, config_timeout_flag,
                                cable_power_drop_flag, state_timeout_flag, PORT_EVENT_FLAG,
                                accel_arb, multi_speed};
        end
        else if (addr_hit(PADDR, `SBC_IDX_IRQ_STATUS))
        begin
            next_prdata[3:0] = irq_status;
        end
        else if (addr_hit(PADDR, `SBC_IDX_IRQ_ENABLE))
        begin
            next_prdata[3:0] = irq_enable;
        end
    end

    // One wait state: PREADY rises in the second access cycle
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            PREADY <= 1'h0;
            PSLVERR <= 1'h0;
            PRDATA <= 32'h0;
        end
        else if (access)
        begin
            PREADY <= 1'h1;
            PSLVERR <= ~mapped;
            PRDATA <= PWRITE ? 32'h0 : next_prdata;
        end
        else
        begin
            PREADY <= 1'h0;
            PSLVERR <= 1'h0;
            PRDATA <= 32'h0;
        end
    end

endmodule : sbc_regs

/* File: hdl/sbc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the PHY configuration bits
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SBC_IDX_CAPS 4'h4
`define SBC_IDX_SELFID 4'h5
`define SBC_IDX_EVENTS 4'h6
`define SBC_IDX_IRQ_STATUS 4'h8
`define SBC_IDX_IRQ_CLEAR 4'h9
`define SBC_IDX_IRQ_ENABLE 4'ha

// ----------------------------------------------------------------------------
// Fixed capability values
// ----------------------------------------------------------------------------
`define SBC_SPEED_CAP 3'h2
`define SBC_REPEATER_DELAY 4'h0
`define SBC_REPEATER_JITTER 3'h0

// ----------------------------------------------------------------------------
// Field positions inside the event register (index 6)
// ----------------------------------------------------------------------------
`define SBC_BIT_RESUME_EN 7
`define SBC_BIT_SHORT_RST 6
`define SBC_BIT_CFG_TO 5
`define SBC_BIT_CPWR_DROP 4
`define SBC_BIT_STATE_TO 3
`define SBC_BIT_PORT_EVT 2
`define SBC_BIT_ACCEL_ARB 1
`define SBC_BIT_MULTI_SPEED 0

// ----------------------------------------------------------------------------
// Field positions inside the self-ID register (index 5)
// ----------------------------------------------------------------------------
`define SBC_BIT_LINK_CTRL 7
`define SBC_BIT_CONTENDER 6

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define SBC_RST_LINK_CTRL 1'h1
`define SBC_RST_CPWR_DROP 1'h1
`define SBC_CLK_PERIOD_NS 4
`define SBC_SHORT_RST_NS 1300
`define SBC_LONG_RST_NS 166000
`define SBC_SHORT_RST_CYCLES ((`SBC_SHORT_RST_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_LONG_RST_CYCLES ((`SBC_LONG_RST_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)

`endif

/* File: hdl/sbc_pkg.sv */
// Types shared by the PHY configuration bit block
package sbc_pkg;

    // Values copied into the transmitted self-ID packet
    typedef struct packed {
        logic link_active;
        logic contender;
        logic [2:0] power_class;
    } sbc_selfid_t;

    // Events from the arbitration controller, same clock
    typedef struct packed {
        logic cfg_timeout;
        logic state_timeout;
        logic resume_start;
        logic bus_reset_seen;
    } sbc_arb_evt_t;

    // Bus reset sequencer states
    typedef enum logic [2:0] {
        SBC_RST_IDLE = 3'b001,
        SBC_RST_WAIT = 3'b010,
        SBC_RST_RUN = 3'b100
    } sbc_rst_state_t;

endpackage : sbc_pkg

/* File: sim/sbc_regs_props.sv */
// Concurrent checks on the ports of the configuration bit block
`timescale 1ns/100ps
module sbc_regs_props #(
    parameter int SHORT_RST_CYCLES = 325,
    parameter int LONG_RST_CYCLES = 20
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic LINK_IF_ENABLE,
    input wire sbc_pkg::sbc_arb_evt_t ARB_EVT,
    input wire logic ARB_IDLE,
    input wire logic SHORT_RESET_OK,
    input wire logic CONTENDER_LINKON_OUT,
    input wire sbc_pkg::sbc_selfid_t SELF_ID,
    input wire logic BUS_RESET_ACTIVE,
    input wire logic BUS_RESET_SHORT,
    input wire logic PORT_EVENT_FLAG
);
    int unsigned run_cnt;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    // Counts the cycles of the bus reset in progress
    always_ff @(posedge SYS_CLK)
    begin
        run_cnt <= (SYS_RST || !BUS_RESET_ACTIVE) ? 0 : run_cnt + 1;
    end
    a_apb_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("access not answered after one wait state");
    a_err_reads_zero: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
        else $error("error response carries data");
    a_short_length: assert property ($fell(BUS_RESET_ACTIVE) && $past(BUS_RESET_SHORT) |-> run_cnt == SHORT_RST_CYCLES)
        else $error("short bus reset length wrong");
    a_long_length: assert property ($fell(BUS_RESET_ACTIVE) && !$past(BUS_RESET_SHORT) |-> run_cnt == LONG_RST_CYCLES)
        else $error("long bus reset length wrong");
    a_short_needs_ok: assert property ($rose(BUS_RESET_ACTIVE) && !$past(SHORT_RESET_OK) |-> !BUS_RESET_SHORT)
        else $error("short reset while a node cannot do it");
    a_reset_waits_idle: assert property ($rose(BUS_RESET_ACTIVE) |-> $past(ARB_IDLE))
        else $error("bus reset started while arbitration busy");
    a_state_to_reset: assert property (ARB_EVT.state_timeout && ARB_IDLE && !BUS_RESET_ACTIVE |-> ##[1:3] BUS_RESET_ACTIVE)
        else $error("state timeout did not start a bus reset");
    a_link_bit_off: assert property (!LINK_IF_ENABLE [*3] |-> !SELF_ID.link_active)
        else $error("link active bit set without link power");
    a_linkon_quiet: assert property (SELF_ID.link_active [*3] |-> !CONTENDER_LINKON_OUT)
        else $error("link-on driven while link active");
    a_port_evt_sticky: assert property (PORT_EVENT_FLAG && !(PSEL && PWRITE) |=> PORT_EVENT_FLAG)
        else $error("port event flag dropped without a write");
endmodule : sbc_regs_props

bind sbc_regs sbc_regs_props #(.SHORT_RST_CYCLES(SHORT_RST_CYCLES), .LONG_RST_CYCLES(LONG_RST_CYCLES)) u_props (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_IF_ENABLE(LINK_IF_ENABLE), .ARB_EVT(ARB_EVT), .ARB_IDLE(ARB_IDLE),
    .SHORT_RESET_OK(SHORT_RESET_OK), .CONTENDER_LINKON_OUT(CONTENDER_LINKON_OUT), .SELF_ID(SELF_ID),
    .BUS_RESET_ACTIVE(BUS_RESET_ACTIVE), .BUS_RESET_SHORT(BUS_RESET_SHORT), .PORT_EVENT_FLAG(PORT_EVENT_FLAG));

/* File: sim/sbc_arb_model.sv */
// Arbitration controller model that raises events and reports when a bus reset may start
`timescale 1ns/100ps
module sbc_arb_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] kick,
    input wire logic slow,
    output sbc_pkg::sbc_arb_evt_t evt,
    output logic idle
);
    logic [3:0] busy;
    // Events are one-cycle pulses, a registered copy of kick
    always_ff @(posedge clk)
    begin
        evt <= rst ? '0 : kick;
    end
    // A slow controller stays busy for a while after each event
    always_ff @(posedge clk)
    begin
        busy <= rst ? 4'h0 : (|kick && slow) ? 4'h9 : (busy != 4'h0) ? busy - 4'h1 : 4'h0;
    end
    assign idle = (busy == 4'h0);
endmodule : sbc_arb_model

/* File: sim/serial_bus_phy_config_status_bits_tb.sv */
// Self-checking bench of the configuration bit block
`timescale 1ns/100ps
module serial_bus_phy_config_status_bits_tb;
    logic clk, rst, psel, penable, pwrite, link_power_status_input, cable_power_sense, cpin, slow, sok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, linkon, lif, bra, brs, pev, irq, idle, e;
    logic [2:0] pcp;
    logic [3:0] kick;
    sbc_pkg::sbc_arb_evt_t evt;
    sbc_pkg::sbc_selfid_t sid;
    int miscompares = 0;
    int samples_checked = 0;
    sbc_regs #(.LONG_RST_CYCLES(20)) uut (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LINK_POWER_STATUS_INPUT(link_power_status_input), .CABLE_POWER_SENSE(cable_power_sense), .CONTENDER_LINKON_PIN(cpin),
        .POWER_CLASS_PINS(pcp), .ARB_EVT(evt), .ARB_IDLE(idle), .SHORT_RESET_OK(sok),
        .CONTENDER_LINKON_OUT(linkon), .LINK_IF_ENABLE(lif), .SELF_ID(sid), .BUS_RESET_ACTIVE(bra),
        .BUS_RESET_SHORT(brs), .PORT_EVENT_FLAG(pev), .IRQ(irq));
    sbc_arb_model partner (.clk(clk), .rst(rst), .kick(kick), .slow(slow), .evt(evt), .idle(idle));
    // Clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // One APB transfer: setup, access until ready, then release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdm(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(name, q & m, x);
    endtask : rdm
    task automatic pulse(input logic [3:0] k);
        kick <= k;
        @(posedge clk);
        kick <= 4'h0;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic wait_br(input logic v);
        while (bra !== v) @(posedge clk);
    endtask : wait_br
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // Watchdog
    initial
    begin
        #200000;
        miscompares++;
        close_out;
    end
    // Test sequence
    initial
    begin
        rst = 1'b1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h0; pwdata = 32'h0; link_power_status_input = 1; cable_power_sense = 1;
        cpin = 1; pcp = 3'h5; kick = 4'h0; slow = 0; sok = 1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdm("caps", 8'h10, 32'hff, 32'h40);
        apb(1'b1, 8'h10, 32'hff);
        rdm("caps_ro", 8'h10, 32'hff, 32'h40);
        rdm("selfid_reg", 8'h14, 32'hff, 32'hc5);
        chk("selfid", sid, 5'h1d);
        rdm("events", 8'h18, 32'hff, 32'h10);
        rdm("unmapped", 8'h3c, 32'hffffffff, 32'h0);
        chk("slverr", e, 1'b1);
        $display("test access done");
        apb(1'b1, 8'h18, 32'h00);
        rdm("w0_keeps", 8'h18, 32'h38, 32'h10);
        apb(1'b1, 8'h18, 32'h10);
        pulse(4'h8);
        rdm("cfg_to", 8'h18, 32'h38, 32'h20);
        apb(1'b1, 8'h28, 32'h1);
        @(posedge clk);
        chk("irq_on", irq, 1'b1);
        apb(1'b1, 8'h24, 32'h1);
        apb(1'b1, 8'h18, 32'h20);
        chk("irq_off", irq, 1'b0);
        rdm("cfg_clr", 8'h18, 32'h20, 32'h0);
        $display("test flags done");
        apb(1'b1, 8'h14, 32'h45);
        repeat (3) @(posedge clk);
        chk("link_bit", sid.link_active, 1'b0);
        chk("if_on", lif, 1'b1);
        apb(1'b1, 8'h18, 32'h80);
        cable_power_sense <= 1'b0;
        repeat (8) @(posedge clk);
        rdm("cpwr_drop", 8'h18, 32'h10, 32'h10);
        chk("linkon", linkon, 1'b1);
        pulse(4'h2);
        chk("port_evt", pev, 1'b1);
        $display("test link done");
        slow <= 1'b1;
        pulse(4'h1);
        apb(1'b1, 8'h18, 32'hc0);
        wait_br(1'b1);
        chk("short", brs, 1'b1);
        wait_br(1'b0);
        rdm("short_reset_request_clr", 8'h18, 32'h40, 32'h0);
        sok <= 1'b0;
        apb(1'b1, 8'h18, 32'hc0);
        wait_br(1'b1);
        chk("long", brs, 1'b0);
        wait_br(1'b0);
        slow <= 1'b0;
        pulse(4'h4);
        wait_br(1'b1);
        wait_br(1'b0);
        rdm("state_to", 8'h18, 32'h08, 32'h08);
        rdm("keep_cfg", 8'h14, 32'hc7, 32'h45);
        $display("test bus reset done");
        close_out;
    end
endmodule : serial_bus_phy_config_status_bits_tb
